// ==== cpesc_pkg.sv ====
// cpesc_pkg: shared types and constants for the coprocessor escape decoder
// assumes: single core clock domain, byte-serial instruction stream
package cpesc_pkg;

  // escape opcode top bits 11011
  localparam logic [4:0] CPESC_ESC_PREFIX = 5'h1B;
  // host stall instruction byte, recognised so it is not flagged
  localparam logic [7:0] CPESC_STALL_OP   = 8'h9B;
  localparam logic [7:0] CPESC_INIT_MODRM = 8'hE3;
  localparam logic [2:0] CPESC_ESC_INIT   = 3'h3;
  localparam logic [2:0] CPESC_ESC_CW     = 3'h1;
  localparam logic [2:0] CPESC_ESC_STATE  = 3'h5;

  // memory-form reg field codes
  localparam logic [2:0] CPESC_REG_LDENV  = 3'h4;
  localparam logic [2:0] CPESC_REG_LDCW   = 3'h5;
  localparam logic [2:0] CPESC_REG_STENV  = 3'h6;
  localparam logic [2:0] CPESC_REG_STCW   = 3'h7;

  localparam logic [2:0] CPESC_RM_DIRECT  = 3'h6;
  localparam logic [1:0] CPESC_KIND_NODISP = 2'h0;
  localparam logic [1:0] CPESC_KIND_DISP8  = 2'h1;
  localparam logic [1:0] CPESC_KIND_DISP16 = 2'h2;
  localparam logic [1:0] CPESC_KIND_REG    = 2'h3;

  // timing figures in clocks of the arithmetic unit
  localparam logic [7:0] CPESC_POP_PENALTY = 8'h05;
  localparam logic [7:0] CPESC_INIT_MIN    = 8'h02;
  localparam logic [7:0] CPESC_INIT_MAX    = 8'h08;
  localparam logic [7:0] CPESC_ENV_ST_MIN  = 8'h28;
  localparam logic [7:0] CPESC_ENV_ST_MAX  = 8'h32;
  localparam logic [7:0] CPESC_ENV_LD_MIN  = 8'h23;
  localparam logic [7:0] CPESC_ENV_LD_MAX  = 8'h2D;
  localparam logic [7:0] CPESC_STATE_MIN   = 8'hC5;
  localparam logic [7:0] CPESC_STATE_MAX   = 8'hCF;
  localparam logic [7:0] CPESC_CW_LD_MIN   = 8'h07;
  localparam logic [7:0] CPESC_CW_LD_MAX   = 8'h0E;
  localparam logic [7:0] CPESC_CW_ST_MIN   = 8'h0C;
  localparam logic [7:0] CPESC_CW_ST_MAX   = 8'h12;

  typedef enum logic [1:0] {
    CPESC_FMT_REAL32,
    CPESC_FMT_INT32,
    CPESC_FMT_REAL64,
    CPESC_FMT_INT16
  } cpesc_fmt_t;

  typedef enum logic [3:0] {
    CPESC_CLS_NONE,
    CPESC_CLS_MEM_ARITH,
    CPESC_CLS_REG_ARITH,
    CPESC_CLS_INIT,
    CPESC_CLS_LOAD_CW,
    CPESC_CLS_STORE_CW,
    CPESC_CLS_STORE_SW,
    CPESC_CLS_STORE_ENV,
    CPESC_CLS_LOAD_ENV,
    CPESC_CLS_SAVE_STATE,
    CPESC_CLS_RESTORE_STATE,
    CPESC_CLS_OTHER,
    CPESC_CLS_HOST_STALL
  } cpesc_class_t;

  // base registers of the host as seen on the shared bus
  typedef struct packed {
    logic [15:0] primary_base;
    logic [15:0] frame_base;
    logic [15:0] source_index;
    logic [15:0] dest_index;
  } cpesc_bases_t;

  typedef struct packed {
    cpesc_class_t op_class;
    cpesc_fmt_t   memory_format;
    logic         is_memory;
    logic [2:0]   stack_index;
    logic         result_to_stack_top;
    logic         reverse_operands;
    logic         stack_remove_flag;
    logic [15:0]  address_offset;
    logic [15:0]  effective_address;
    logic [7:0]   extra_clocks;
    logic [7:0]   clocks_min;
    logic [7:0]   clocks_max;
    logic         unknown;
  } cpesc_decode_t;

endpackage

// ==== cpesc_ea_calc.sv ====
// cpesc_ea_calc: effective address from locator, bases and offset
// assumes: purely combinational, inputs stable in the core clock domain
`timescale 1ns/1ns
`default_nettype none
module cpesc_ea_calc (
  // decode fields
  input  wire logic [1:0]          addressing_kind,
  input  wire logic [2:0]          operand_locator,
  input  wire logic [15:0]         address_offset,
  // host base registers
  input  wire cpesc_pkg::cpesc_bases_t bases,
  // result
  output logic [15:0]              effective_address
);
  import cpesc_pkg::*;

  logic [15:0] base_sum;

  always_comb begin
    unique case (operand_locator)
      3'h0: base_sum = bases.primary_base + bases.source_index;
      3'h1: base_sum = bases.primary_base + bases.dest_index;
      3'h2: base_sum = bases.frame_base + bases.source_index;
      3'h3: base_sum = bases.frame_base + bases.dest_index;
      3'h4: base_sum = bases.source_index;
      3'h5: base_sum = bases.dest_index;
      3'h6: base_sum = bases.frame_base;
      3'h7: base_sum = bases.primary_base;
    endcase
    // direct form: displacement alone, no base
    if (addressing_kind == CPESC_KIND_NODISP &&
        operand_locator == CPESC_RM_DIRECT) begin
      effective_address = address_offset;
    end else begin
      effective_address = base_sum + address_offset;
    end
  end
endmodule
`default_nettype wire

// ==== cpesc_decoder.sv ====
// cpesc_decoder: byte-serial decoder of coprocessor escape instructions
// assumes: host presents one instruction byte per byte_valid pulse,
// on the core clock; base registers are stable during the instruction
`timescale 1ns/1ns
`default_nettype none
module cpesc_decoder (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rstn,
  // instruction byte stream
  input  wire logic                    byte_valid,
  input  wire logic [7:0]              byte_data,
  // host base registers
  input  wire cpesc_pkg::cpesc_bases_t bases,
  // decoded result
  output logic                         decode_valid,
  output cpesc_pkg::cpesc_decode_t     decode,
  output logic                         busy
);
  import cpesc_pkg::*;

  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_MODRM,
    ST_DISP_LO,
    ST_DISP_HI,
    ST_EMIT
  } cpesc_state_t;

  typedef struct packed {
    cpesc_state_t  state;
    logic [2:0]    esc_bits;
    logic [7:0]    modrm;
    logic [15:0]   disp;
    logic          stall_op;
    logic          valid;
    cpesc_decode_t dec;
  } cpesc_regs_t;

  cpesc_regs_t r_r;
  cpesc_regs_t r_nxt;
  cpesc_decode_t dec_c;
  logic [15:0] ea_c;
  logic [1:0]  kind_c;
  logic [2:0]  loc_c;
  logic [2:0]  reg_c;
  logic [15:0] offs_c;

  assign kind_c = r_r.modrm[7:6];
  assign reg_c  = r_r.modrm[5:3];
  assign loc_c  = r_r.modrm[2:0];

  always_comb begin
    unique case (kind_c)
      CPESC_KIND_DISP8:  offs_c = r_r.disp;
      CPESC_KIND_DISP16: offs_c = r_r.disp;
      CPESC_KIND_NODISP: begin
        // zero unless direct form
        offs_c = (loc_c == CPESC_RM_DIRECT) ? r_r.disp : 16'h0000;
      end
      CPESC_KIND_REG:    offs_c = 16'h0000;
    endcase
  end

  cpesc_ea_calc u_ea (
    .addressing_kind   (kind_c),
    .operand_locator   (loc_c),
    .address_offset    (offs_c),
    .bases             (bases),
    .effective_address (ea_c)
  );

  // classification of a complete instruction
  always_comb begin
    dec_c = '0;
    dec_c.memory_format  = cpesc_fmt_t'(r_r.esc_bits[2:1]);
    dec_c.address_offset = offs_c;
    if (r_r.stall_op) begin
      dec_c.op_class = CPESC_CLS_HOST_STALL;
    end else if (kind_c != CPESC_KIND_REG) begin
      dec_c.is_memory         = 1'b1;
      dec_c.effective_address = ea_c;
      dec_c.op_class          = CPESC_CLS_MEM_ARITH;
      if (r_r.esc_bits == CPESC_ESC_CW) begin
        unique case (reg_c)
          CPESC_REG_LDCW: begin
            dec_c.op_class   = CPESC_CLS_LOAD_CW;
            dec_c.clocks_min = CPESC_CW_LD_MIN;
            dec_c.clocks_max = CPESC_CW_LD_MAX;
          end
          CPESC_REG_STCW: begin
            dec_c.op_class   = CPESC_CLS_STORE_CW;
            dec_c.clocks_min = CPESC_CW_ST_MIN;
            dec_c.clocks_max = CPESC_CW_ST_MAX;
          end
          CPESC_REG_STENV: begin
            dec_c.op_class   = CPESC_CLS_STORE_ENV;
            dec_c.clocks_min = CPESC_ENV_ST_MIN;
            dec_c.clocks_max = CPESC_ENV_ST_MAX;
          end
          CPESC_REG_LDENV: begin
            dec_c.op_class   = CPESC_CLS_LOAD_ENV;
            dec_c.clocks_min = CPESC_ENV_LD_MIN;
            dec_c.clocks_max = CPESC_ENV_LD_MAX;
          end
          default: dec_c.op_class = CPESC_CLS_OTHER;
        endcase
      end else if (r_r.esc_bits == CPESC_ESC_STATE) begin
        unique case (reg_c)
          CPESC_REG_STCW: begin
            dec_c.op_class   = CPESC_CLS_STORE_SW;
            dec_c.clocks_min = CPESC_CW_ST_MIN;
            dec_c.clocks_max = CPESC_CW_ST_MAX;
          end
          CPESC_REG_STENV: begin
            dec_c.op_class   = CPESC_CLS_SAVE_STATE;
            dec_c.clocks_min = CPESC_STATE_MIN;
            dec_c.clocks_max = CPESC_STATE_MAX;
          end
          CPESC_REG_LDENV: begin
            dec_c.op_class   = CPESC_CLS_RESTORE_STATE;
            dec_c.clocks_min = CPESC_STATE_MIN;
            dec_c.clocks_max = CPESC_STATE_MAX;
          end
          default: dec_c.op_class = CPESC_CLS_OTHER;
        endcase
      end else if (r_r.esc_bits[0]) begin
        dec_c.op_class = CPESC_CLS_OTHER;
      end
    end else begin
      // register form; index counts down from the stack top
      dec_c.stack_index = loc_c;
      if (r_r.esc_bits == CPESC_ESC_INIT && r_r.modrm == CPESC_INIT_MODRM) begin
        dec_c.op_class   = CPESC_CLS_INIT;
        dec_c.clocks_min = CPESC_INIT_MIN;
        dec_c.clocks_max = CPESC_INIT_MAX;
      end else if (!r_r.esc_bits[0]) begin
        dec_c.op_class            = CPESC_CLS_REG_ARITH;
        dec_c.result_to_stack_top = !r_r.esc_bits[2];
        dec_c.reverse_operands    = reg_c[0] ^ r_r.esc_bits[2];
        dec_c.stack_remove_flag   = r_r.esc_bits[1];
        dec_c.extra_clocks = r_r.esc_bits[1] ? CPESC_POP_PENALTY
                                             : 8'h00;
      end else begin
        dec_c.op_class = CPESC_CLS_OTHER;
      end
    end
    dec_c.unknown = (dec_c.op_class == CPESC_CLS_NONE);
  end

  always_comb begin
    r_nxt       = r_r;
    r_nxt.valid = 1'b0;
    unique case (r_r.state)
      ST_OPCODE: begin
        if (byte_valid) begin
          r_nxt.stall_op = 1'b0;
          r_nxt.disp     = 16'h0000;
          r_nxt.modrm    = 8'h00;
          if (byte_data == CPESC_STALL_OP) begin
            r_nxt.stall_op = 1'b1;
            r_nxt.modrm    = 8'hC0;
            r_nxt.state    = ST_EMIT;
          end else if (byte_data[7:3] == CPESC_ESC_PREFIX) begin
            r_nxt.esc_bits = byte_data[2:0];
            r_nxt.state    = ST_MODRM;
          end else begin
            r_nxt.valid       = 1'b1;
            r_nxt.dec         = '0;
            r_nxt.dec.unknown = 1'b1;
          end
        end
      end
      ST_MODRM: begin
        if (byte_valid) begin
          r_nxt.modrm = byte_data;
          unique case (byte_data[7:6])
            CPESC_KIND_NODISP: begin
              r_nxt.state = (byte_data[2:0] == CPESC_RM_DIRECT)
                            ? ST_DISP_LO : ST_EMIT;
            end
            CPESC_KIND_DISP8:  r_nxt.state = ST_DISP_LO;
            CPESC_KIND_DISP16: r_nxt.state = ST_DISP_LO;
            CPESC_KIND_REG:    r_nxt.state = ST_EMIT;
          endcase
        end
      end
      ST_DISP_LO: begin
        if (byte_valid) begin
          if (kind_c == CPESC_KIND_DISP8) begin
            r_nxt.disp  = {{8{byte_data[7]}}, byte_data};
            r_nxt.state = ST_EMIT;
          end else begin
            r_nxt.disp  = {8'h00, byte_data};
            r_nxt.state = ST_DISP_HI;
          end
        end
      end
      ST_DISP_HI: begin
        if (byte_valid) begin
          r_nxt.disp[15:8] = byte_data;
          r_nxt.state      = ST_EMIT;
        end
      end
      ST_EMIT: begin
        r_nxt.dec   = dec_c;
        r_nxt.valid = 1'b1;
        r_nxt.state = ST_OPCODE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign decode_valid = r_r.valid;
  assign decode       = r_r.dec;
  assign busy         = (r_r.state != ST_OPCODE);

  AST_POP_PENALTY: assert property (
    @(posedge core_clk) disable iff (!rstn)
    decode_valid && decode.op_class == CPESC_CLS_REG_ARITH
    |-> decode.extra_clocks == (decode.stack_remove_flag ? 8'h05 : 8'h00))
    else $error("pop penalty wrong");
  AST_REG_TARGET: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (r_r.state == ST_EMIT && kind_c == CPESC_KIND_REG && !r_r.stall_op
     && r_r.esc_bits[0] == 1'b0 && r_r.modrm != CPESC_INIT_MODRM)
    |=> decode_valid && decode.result_to_stack_top == !$past(r_r.esc_bits[2]))
    else $error("target choice wrong");
  AST_REVERSE: assert property (
    @(posedge core_clk) disable iff (!rstn)
    decode_valid && decode.op_class == CPESC_CLS_REG_ARITH
    |-> decode.reverse_operands
        == ($past(r_r.modrm[3]) ^ !decode.result_to_stack_top))
    else $error("reverse sense wrong");
  AST_DISP8: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (r_r.state == ST_DISP_LO && byte_valid && kind_c == CPESC_KIND_DISP8)
    |=> ##1 decode_valid
        && decode.address_offset == {{8{$past(byte_data[7], 2)}},
                                     $past(byte_data, 2)})
    else $error("disp8 sign extension wrong");
  AST_DISP16: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (r_r.state == ST_DISP_HI && byte_valid)
    |=> ##1 decode_valid && decode.address_offset[15:8] == $past(byte_data, 2))
    else $error("disp16 high byte wrong");
  AST_NODISP: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (r_r.state == ST_MODRM && byte_valid && byte_data[7:6] == 2'h0
     && byte_data[2:0] != 3'h6)
    |=> ##1 decode_valid && decode.address_offset == 16'h0000)
    else $error("mode 00 offset not zero");
  AST_DIRECT: assert property (
    @(posedge core_clk) disable iff (!rstn)
    decode_valid && decode.is_memory && $past(kind_c) == 2'h0
    && $past(loc_c) == 3'h6
    |-> decode.effective_address == decode.address_offset)
    else $error("direct address wrong");
  AST_INIT: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (r_r.state == ST_EMIT && !r_r.stall_op && r_r.esc_bits == 3'h3
     && r_r.modrm == 8'hE3)
    |=> decode_valid && decode.op_class == CPESC_CLS_INIT
        && decode.clocks_min == 8'h02 && decode.clocks_max == 8'h08)
    else $error("init not recognised");
  AST_ONE_CLOCK: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (r_r.state == ST_EMIT) |=> decode_valid && r_r.state == ST_OPCODE)
    else $error("decode not one clock later");
  AST_STACK_IDX: assert property (
    @(posedge core_clk) disable iff (!rstn)
    decode_valid && decode.op_class == CPESC_CLS_REG_ARITH
    |-> decode.stack_index == $past(r_r.modrm[2:0]))
    else $error("stack index wrong");
  AST_FORMAT: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (r_r.state == ST_EMIT && !r_r.stall_op)
    |=> decode.memory_format == $past(r_r.esc_bits[2:1]))
    else $error("memory format wrong");
  AST_POP_FLAG: assert property (
    @(posedge core_clk) disable iff (!rstn)
    decode_valid && decode.op_class == CPESC_CLS_REG_ARITH
    |-> decode.stack_remove_flag == $past(r_r.esc_bits[1]))
    else $error("pop flag wrong");
  // a stray byte must not be taken for an escape or a stall
  AST_UNKNOWN: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (r_r.state == ST_OPCODE && byte_valid && byte_data != 8'h9B
     && byte_data[7:3] != 5'h1B)
    |=> decode_valid && decode.unknown)
    else $error("unknown opcode not flagged");
  AST_STORE_SW: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (r_r.state == ST_EMIT && !r_r.stall_op && r_r.modrm[7:6] != 2'h3
     && r_r.esc_bits == 3'h5 && r_r.modrm[5:3] == 3'h7)
    |=> decode_valid && decode.op_class == CPESC_CLS_STORE_SW)
    else $error("status store not recognised");
endmodule
`default_nettype wire

// ==== cpesc_host_model.sv ====
// cpesc_host_model: host side feeding instruction bytes to the decoder
// assumes: one byte per clock while valid, driven 1 ns after the edge
`timescale 1ns/1ns
`default_nettype none
module cpesc_host_model (
  // clock
  input  wire logic       core_clk,
  // byte stream
  output logic            byte_valid,
  output logic [7:0]      byte_data
);
  initial begin
    byte_valid = 1'b0;
    byte_data  = 8'h00;
  end

  // stall byte goes through here as a one-byte instruction
  task automatic send(input logic [7:0] q[$]);
    foreach (q[k]) begin
      @(posedge core_clk);
      #1;
      byte_valid = 1'b1;
      byte_data  = q[k];
    end
    @(posedge core_clk);
    #1;
    byte_valid = 1'b0;
    // released line must not look like the last byte
    byte_data  = ~byte_data;
  endtask
endmodule
`default_nettype wire

// ==== cpesc_tb.sv ====
// tb: self-checking bench for the escape decoder
// assumes: cpesc_pkg and the decoder sources compiled before this file
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, (a), (e)); end end
module tb;
  import cpesc_pkg::*;
  logic          core_clk;
  logic          rstn;
  logic          byte_valid;
  logic [7:0]    byte_data;
  cpesc_bases_t  bases;
  logic          decode_valid;
  cpesc_decode_t dec;
  logic          busy;
  logic [7:0]    q[$];
  logic [15:0]   disp;
  logic [7:0]    d8;
  int            bad_count;
  int            compares;

  cpesc_host_model host (
    .core_clk   (core_clk),
    .byte_valid (byte_valid),
    .byte_data  (byte_data)
  );
  cpesc_decoder dut (
    .core_clk     (core_clk),
    .rstn         (rstn),
    .byte_valid   (byte_valid),
    .byte_data    (byte_data),
    .bases        (bases),
    .decode_valid (decode_valid),
    .decode       (dec),
    .busy         (busy)
  );

  always #20 core_clk = ~core_clk;

  function automatic logic [15:0] ea_exp(input logic [2:0] loc,
                                         input logic [15:0] off);
    case (loc)
      3'h0: ea_exp = bases.primary_base + bases.source_index + off;
      3'h1: ea_exp = bases.primary_base + bases.dest_index + off;
      3'h2: ea_exp = bases.frame_base + bases.source_index + off;
      3'h3: ea_exp = bases.frame_base + bases.dest_index + off;
      3'h4: ea_exp = bases.source_index + off;
      3'h5: ea_exp = bases.dest_index + off;
      3'h6: ea_exp = bases.frame_base + off;
      default: ea_exp = bases.primary_base + off;
    endcase
  endfunction

  task automatic conclude;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // send q, then count cycles until the result pulse
  task automatic issue(input int lat);
    int n;
    // the edge that takes the last byte counts as the first cycle
    n = 1;
    host.send(q);
    if (q.size() > 1) `CHK(busy, 1'b1);
    while (n < 5 && decode_valid !== 1'b1) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    `CHK(n, lat);
  endtask

  task automatic chk_mem(input logic [2:0] loc, input logic [15:0] off);
    `CHK(dec.is_memory, 1'b1);
    `CHK(dec.address_offset, off);
    `CHK(dec.effective_address, ea_exp(loc, off));
  endtask

  task automatic ctl(input logic [2:0] esc, input logic [2:0] rg,
                     input cpesc_class_t cls, input logic [7:0] mn,
                     input logic [7:0] mx);
    q = '{{CPESC_ESC_PREFIX, esc}, {2'b00, rg, 3'b111}};
    issue(2);
    `CHK(dec.op_class, cls);
    `CHK(dec.clocks_min, mn);
    `CHK(dec.clocks_max, mx);
    chk_mem(3'h7, 16'h0000);
  endtask

  initial begin
    core_clk  = 1'b0;
    rstn      = 1'b0;
    bad_count = 0;
    compares  = 0;
    bases     = '{16'h1230, 16'h4500, 16'h0067, 16'h0809};
    repeat (16) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    @(posedge core_clk);
    #1;
    `CHK(decode_valid, 1'b0);
    `CHK(busy, 1'b0);
    `CHK(dec, '0);
    // every locator and format, two-byte displacement
    for (int r = 0; r < 8; r++) begin
      disp = 16'hA55A ^ {13'h0000, r[2:0]};
      q = '{{CPESC_ESC_PREFIX, r[1:0], 1'b0}, {5'b10010, r[2:0]},
            disp[7:0], disp[15:8]};
      issue(2);
      `CHK(dec.op_class, CPESC_CLS_MEM_ARITH);
      `CHK(dec.memory_format, cpesc_fmt_t'(r[1:0]));
      chk_mem(r[2:0], disp);
    end
    // one-byte displacement, both signs
    for (int k = 0; k < 2; k++) begin
      d8 = (k == 0) ? 8'h80 : 8'h7F;
      q = '{8'hDC, 8'h43, d8};
      issue(2);
      chk_mem(3'h3, {{8{d8[7]}}, d8});
    end
    // no displacement, then the direct form
    q = '{8'hD8, 8'h01};
    issue(2);
    chk_mem(3'h1, 16'h0000);
    q = '{8'hD8, 8'h06, 8'h34, 8'h12};
    issue(2);
    `CHK(dec.effective_address, 16'h1234);
    // register form: every d, P, R with stack index 0..7
    for (int c = 0; c < 8; c++) begin
      q = '{{CPESC_ESC_PREFIX, c[2:1], 1'b0}, {4'b1110, c[0], c[2:0]}};
      issue(2);
      `CHK(dec.op_class, CPESC_CLS_REG_ARITH);
      `CHK(dec.is_memory, 1'b0);
      `CHK(dec.stack_index, c[2:0]);
      `CHK(dec.result_to_stack_top, ~c[2]);
      `CHK(dec.reverse_operands, c[0] ^ c[2]);
      `CHK(dec.stack_remove_flag, c[1]);
      `CHK(dec.extra_clocks, c[1] ? 8'h05 : 8'h00);
    end
    q = '{{CPESC_ESC_PREFIX, 3'h3}, 8'hE3};
    issue(2);
    `CHK(dec.op_class, CPESC_CLS_INIT);
    `CHK(dec.clocks_min, 8'h02);
    `CHK(dec.clocks_max, 8'h08);
    ctl(3'h1, 3'h5, CPESC_CLS_LOAD_CW, 8'h07, 8'h0E);
    ctl(3'h1, 3'h7, CPESC_CLS_STORE_CW, 8'h0C, 8'h12);
    ctl(3'h5, 3'h7, CPESC_CLS_STORE_SW, 8'h0C, 8'h12);
    ctl(3'h5, 3'h6, CPESC_CLS_SAVE_STATE, 8'hC5, 8'hCF);
    ctl(3'h5, 3'h4, CPESC_CLS_RESTORE_STATE, 8'hC5, 8'hCF);
    ctl(3'h1, 3'h6, CPESC_CLS_STORE_ENV, 8'h28, 8'h32);
    ctl(3'h1, 3'h4, CPESC_CLS_LOAD_ENV, 8'h23, 8'h2D);
    ctl(3'h1, 3'h0, CPESC_CLS_OTHER, 8'h00, 8'h00);
    // operand ranges are the caller's duty; only the class is seen here
    q = '{8'hD9, 8'hFD};
    issue(2);
    `CHK(dec.op_class, CPESC_CLS_OTHER);
    q = '{8'hD9, 8'hF2};
    issue(2);
    `CHK(dec.op_class, CPESC_CLS_OTHER);
    q = '{CPESC_STALL_OP};
    issue(2);
    `CHK(dec.op_class, CPESC_CLS_HOST_STALL);
    `CHK(dec.unknown, 1'b0);
    q = '{8'h90};
    issue(1);
    `CHK(dec.unknown, 1'b1);
    // reset in mid-run clears the held result
    rstn = 1'b0;
    @(posedge core_clk);
    #1;
    rstn = 1'b1;
    @(posedge core_clk);
    #1;
    `CHK(decode_valid, 1'b0);
    `CHK(busy, 1'b0);
    `CHK(dec, '0);
    q = '{CPESC_STALL_OP};
    issue(2);
    `CHK(dec.op_class, CPESC_CLS_HOST_STALL);
    conclude();
  end

  // whole run is under 200 cycles; this is 10000 cycles, some fifty times that
  initial begin
    #400000;
    bad_count++;
    conclude();
  end
endmodule
`default_nettype wire
